/* rtl/htx_framer.sv */
// Device end: HDLC transmit framer with byte demand clock
// Notes on behaviour
// R1 - Message high: latch byte each falling edge
// R2 - Idle: send continuous 0x7E flags
// R3 - Ignore input bus while message low
// R4 - Terminal changes bus on rising edge
// R5 - Output byte demand clock, pauses for stuffing
// R6 - Serialise bytes least significant bit first
// R7 - Zero stuffing prevents flag/abort imitation
// R8 - 16-bit mode: check command two periods
// R9 - 32-bit mode: check command four periods
// R10 - Check command appends computed check trailer
// R11 - Check command with message low outside a frame aborts
// R12 - HDLC mode assigns shared pins
// R13 - Transmitter runs only when mode enabled
// R14 - Width select: one is 32-bit check
// R15 - Stuff after five ones; closing flag after check
// R16 - Standard polynomials, preset ones, complemented
`timescale 1ns/10ps
`default_nettype none
module htx_framer (
   input wire logic sys_clk,
   input wire logic sys_rst,
   htx_link_if.dev link,
   input wire logic hdlc_enable,
   input wire logic crc32_select,
   output logic line_bit,
   output logic line_bit_valid,
   output logic pins_hdlc_mode
);
   typedef struct packed {
      logic [3:0] div;
      logic [7:0] shreg;
      logic [2:0] bit_idx;
      htx_pkg::htx_src_t src;
      logic [2:0] ones;
      logic [31:0] crc;
      logic [2:0] crc_left;
      logic in_frame;
      logic demand_clk;
      logic [7:0] held;
      logic held_valid;
      logic held_abort;
      logic held_check;
      logic msg_d;
      logic fcs_d;
      logic line_bit;
      logic line_valid;
      logic pins_mode;
   } htx_fr_t;

   htx_fr_t st_reg;
   htx_fr_t st_next;

   // One CRC step over one bit, reflected form
   function automatic logic [31:0] htx_crc_bit(input logic [31:0] c,
                                               input logic b,
                                               input logic wide);
      logic fb;
      logic [31:0] r;
      fb = c[0] ^ b;
      r = c >> 1;
      if (fb)
      begin
         r = r ^ (wide ? htx_pkg::HTX_CRC32_POLY
                       : {16'h0000, htx_pkg::HTX_CRC16_POLY});
      end
      return r;
   endfunction

   // Next state: byte sampling, bit serialisation, stuffing, check
   always_comb
   begin
      logic bit_out;
      logic stuff;
      logic tick;
      logic byte_done;
      st_next = st_reg;
      bit_out = st_reg.shreg[0];
      stuff = 1'b0;
      tick = 1'b0;
      byte_done = 1'b0;
      st_next.line_valid = 1'b0;
      st_next.pins_mode = hdlc_enable; // see R12
      st_next.msg_d = link.send_msg_cmd;
      st_next.fcs_d = link.append_check_cmd;
      if (!hdlc_enable) // see R13
      begin
         st_next.div = 4'h0;
         st_next.bit_idx = 3'h0;
         st_next.ones = 3'h0;
         st_next.src = htx_pkg::HTX_SRC_FLAG;
         st_next.shreg = htx_pkg::HTX_FLAG;
         st_next.in_frame = 1'b0;
         st_next.held_valid = 1'b0;
         st_next.held_abort = 1'b0;
         st_next.held_check = 1'b0;
         st_next.demand_clk = 1'b0;
      end
      else
      begin
         // Sample on the falling demand edge, set at bit slot three
         if (st_reg.demand_clk && (st_reg.bit_idx == htx_pkg::HTX_HALF_BIT)
             && !st_reg.held_valid && (st_reg.div == 4'h0))
         begin
            st_next.demand_clk = 1'b0;
            if (st_reg.msg_d) // see R1, R4
            begin
               st_next.held = link.tx_byte_input_bus;
               st_next.held_valid = 1'b1;
            end
            else if (st_reg.fcs_d && !st_reg.in_frame) // see R11
            begin
               st_next.held_abort = 1'b1;
            end
            else if (st_reg.fcs_d && st_reg.in_frame) // see R8, R9, R10
            begin
               st_next.held_check = 1'b1;
            end
            // Otherwise the bus value is dropped, see R3
         end
         st_next.div = st_reg.div + 4'h1;
         if (st_reg.div == htx_pkg::HTX_BIT_DIV - 4'h1)
         begin
            st_next.div = 4'h0;
            tick = 1'b1;
         end
         if (tick)
         begin
            // Stuffed zero holds the byte, slowing the demand clock, see R5
            // Five ones that close the check still get their zero
            stuff = (st_reg.src == htx_pkg::HTX_SRC_DATA
                     || st_reg.src == htx_pkg::HTX_SRC_CRC
                     || (st_reg.src == htx_pkg::HTX_SRC_FLAG
                         && st_reg.bit_idx == 3'h0))
                    && st_reg.ones == htx_pkg::HTX_ONES_LIMIT; // see R7, R15
            st_next.line_valid = 1'b1;
            if (stuff)
            begin
               st_next.line_bit = 1'b0;
               st_next.ones = 3'h0;
            end
            else
            begin
               st_next.line_bit = bit_out; // see R6
               st_next.ones = bit_out ? st_reg.ones + 3'h1 : 3'h0;
               st_next.shreg = st_reg.shreg >> 1;
               st_next.bit_idx = st_reg.bit_idx + 3'h1;
               if (st_reg.src == htx_pkg::HTX_SRC_DATA)
               begin
                  st_next.crc = htx_crc_bit(st_reg.crc, bit_out,
                                            crc32_select); // see R14, R16
               end
               byte_done = st_reg.bit_idx == htx_pkg::HTX_LAST_BIT;
               if (st_reg.bit_idx == htx_pkg::HTX_LAST_BIT - 3'h3)
               begin
                  st_next.demand_clk = 1'b1; // see R5
               end
            end
         end
         // Choose the next byte at each byte boundary
         if (byte_done)
         begin
            st_next.held_valid = 1'b0;
            st_next.held_abort = 1'b0;
            st_next.held_check = 1'b0;
            if (st_reg.src == htx_pkg::HTX_SRC_CRC
                && st_reg.crc_left != 3'h0)
            begin
               st_next.shreg = st_reg.crc[7:0];
               st_next.crc = st_reg.crc >> 8;
               st_next.crc_left = st_reg.crc_left - 3'h1;
            end
            else if (st_reg.held_valid)
            begin
               if (!st_reg.in_frame)
               begin
                  st_next.crc = crc32_select ? htx_pkg::HTX_CRC_PRESET
                     : htx_pkg::HTX_CRC_PRESET & htx_pkg::HTX_CRC16_MASK;
               end
               st_next.src = htx_pkg::HTX_SRC_DATA;
               st_next.shreg = st_reg.held;
               st_next.in_frame = 1'b1;
            end
            else if (st_reg.held_check)
            begin
               // Complemented check value, low byte first, see R10, R16
               st_next.src = htx_pkg::HTX_SRC_CRC;
               // Updated value already holds the last data bit
               st_next.shreg = ~st_next.crc[7:0];
               st_next.crc = ~st_next.crc >> 8;
               st_next.crc_left = (crc32_select ? htx_pkg::HTX_CRC32_BYTES
                                   : htx_pkg::HTX_CRC16_BYTES) - 3'h1;
               st_next.in_frame = 1'b0;
            end
            else if (st_reg.held_abort)
            begin
               st_next.src = htx_pkg::HTX_SRC_ABORT; // see R11
               st_next.shreg = htx_pkg::HTX_ABORT;
               st_next.in_frame = 1'b0;
            end
            else
            begin
               // Closing flag after check, then idle flags, see R2, R15
               st_next.src = htx_pkg::HTX_SRC_FLAG;
               st_next.shreg = htx_pkg::HTX_FLAG;
               st_next.in_frame = 1'b0;
            end
            if (st_reg.src != htx_pkg::HTX_SRC_CRC
                || st_reg.crc_left == 3'h0)
            begin
               st_next.ones = stuff ? 3'h0 : st_next.ones;
            end
         end
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
         st_reg.shreg <= htx_pkg::HTX_FLAG;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign link.tx_byte_demand_clock = st_reg.demand_clk;
   assign line_bit = st_reg.line_bit;
   assign line_bit_valid = st_reg.line_valid;
   assign pins_hdlc_mode = st_reg.pins_mode;
endmodule
`default_nettype wire

/* rtl/htx_pkg.sv */
// Shared constants and types for the HDLC transmit byte port
package htx_pkg;
   localparam logic [7:0] HTX_FLAG = 8'h7E;
   localparam logic [7:0] HTX_ABORT = 8'hFF;
   localparam logic [2:0] HTX_ONES_LIMIT = 3'h5;
   localparam logic [2:0] HTX_LAST_BIT = 3'h7;
   localparam logic [2:0] HTX_HALF_BIT = 3'h3;
   localparam logic [15:0] HTX_CRC16_POLY = 16'h8408;
   localparam logic [31:0] HTX_CRC32_POLY = 32'hEDB88320;
   localparam logic [31:0] HTX_CRC_PRESET = 32'hFFFFFFFF;
   localparam logic [31:0] HTX_CRC16_MASK = 32'h0000FFFF;
   localparam logic [2:0] HTX_CRC16_BYTES = 3'h2;
   localparam logic [2:0] HTX_CRC32_BYTES = 3'h4;
   // Line bit pacing: one line bit, payload or stuffed zero, every HTX_BIT_DIV system clocks
   localparam logic [3:0] HTX_BIT_DIV = 4'h4;
   typedef enum logic [1:0] {HTX_SRC_FLAG, HTX_SRC_DATA, HTX_SRC_CRC,
                             HTX_SRC_ABORT} htx_src_t;
endpackage

/* rtl/htx_link_if.sv */
// Byte port between terminal logic and the HDLC transmitter
`timescale 1ns/10ps
`default_nettype none
interface htx_link_if;
   logic tx_byte_demand_clock;
   logic [7:0] tx_byte_input_bus;
   logic send_msg_cmd;
   logic append_check_cmd;
   modport dev (
      output tx_byte_demand_clock,
      input tx_byte_input_bus,
      input send_msg_cmd,
      input append_check_cmd
   );
   modport term (
      input tx_byte_demand_clock,
      output tx_byte_input_bus,
      output send_msg_cmd,
      output append_check_cmd
   );
endinterface
`default_nettype wire

/* rtl/htx_terminal.sv */
// Terminal end: feeds frames byte by byte on the demand clock
`timescale 1ns/10ps
`default_nettype none
module htx_terminal (
   input wire logic sys_clk,
   input wire logic sys_rst,
   htx_link_if.term link,
   input wire logic crc32_select,
   input wire logic [7:0] user_data,
   input wire logic user_valid,
   input wire logic user_last,
   input wire logic user_abort,
   output logic user_ready
);
   typedef enum logic [1:0] {HTX_T_IDLE, HTX_T_DATA, HTX_T_CHECK,
                             HTX_T_ABORT} htx_term_state_t;
   typedef struct packed {
      htx_term_state_t state;
      logic clk_d;
      logic [2:0] left;
      logic [7:0] bus;
      logic msg;
      logic fcs;
      logic ready;
   } htx_term_t;

   htx_term_t st_reg;
   htx_term_t st_next;

   // Drive bus and commands on the rising demand edge, see R4
   always_comb
   begin
      logic rise;
      st_next = st_reg;
      st_next.clk_d = link.tx_byte_demand_clock;
      rise = link.tx_byte_demand_clock && !st_reg.clk_d;
      st_next.ready = 1'b0;
      if (rise)
      begin
         case (st_reg.state)
            HTX_T_IDLE, HTX_T_DATA:
            begin
               st_next.msg = 1'b0;
               st_next.fcs = 1'b0;
               if (user_abort)
               begin
                  st_next.fcs = 1'b1; // see R11
                  st_next.state = HTX_T_ABORT;
               end
               else if (user_valid)
               begin
                  st_next.bus = user_data;
                  st_next.msg = 1'b1;
                  st_next.ready = 1'b1;
                  st_next.state = user_last ? HTX_T_CHECK : HTX_T_DATA;
                  st_next.left = crc32_select ? htx_pkg::HTX_CRC32_BYTES
                                              : htx_pkg::HTX_CRC16_BYTES;
               end
            end
            HTX_T_CHECK:
            begin
               st_next.msg = 1'b0;
               st_next.fcs = st_reg.left != 3'h0; // see R8, R9
               st_next.left = st_reg.left - 3'h1;
               if (st_reg.left == 3'h0)
               begin
                  st_next.state = HTX_T_IDLE;
               end
            end
            default:
            begin
               st_next.fcs = 1'b0;
               st_next.state = HTX_T_IDLE;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign link.tx_byte_input_bus = st_reg.bus;
   assign link.send_msg_cmd = st_reg.msg;
   assign link.append_check_cmd = st_reg.fcs;
   assign user_ready = st_reg.ready;
endmodule
`default_nettype wire

/* bench/htx_link_monitor.sv */
// Checker on the byte port between terminal and framer
`timescale 1ns/10ps
`default_nettype none
module htx_link_monitor (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic hdlc_enable,
   input wire logic crc32_select,
   input wire logic tx_byte_demand_clock,
   input wire logic [7:0] tx_byte_input_bus,
   input wire logic send_msg_cmd,
   input wire logic append_check_cmd
);
   wire logic dclk = tx_byte_demand_clock;
   wire logic msg = send_msg_cmd;
   wire logic fcs = append_check_cmd;
   logic in_frame_reg;
   logic [2:0] nfall_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Frame flag and byte samples taken under the check command
   always_ff @(posedge sys_clk)
   begin
      in_frame_reg <= !sys_rst && (msg || (in_frame_reg && !$fell(fcs)));
      nfall_reg <= (sys_rst || !fcs) ? 3'h0 : nfall_reg + 3'($fell(dclk));
   end
   property p_bus_steady;
      $fell(dclk) && msg |-> $stable(tx_byte_input_bus);
   endproperty
   a_bus_steady: assert property (p_bus_steady)
      else $error("bus moved at sample");
   property p_cmd_steady;
      $fell(dclk) |-> $stable(msg) && $stable(fcs);
   endproperty
   a_cmd_steady: assert property (p_cmd_steady)
      else $error("command moved at sample");
   property p_bus_launch;
      $changed(tx_byte_input_bus) |-> dclk;
   endproperty
   a_bus_launch: assert property (p_bus_launch)
      else $error("bus moved with clock low");
   property p_msg_launch;
      $changed(msg) |-> dclk && $past(dclk);
   endproperty
   a_msg_launch: assert property (p_msg_launch)
      else $error("message moved off rise");
   property p_fcs_launch;
      $rose(fcs) |-> dclk ##1 fcs;
   endproperty
   a_fcs_launch: assert property (p_fcs_launch)
      else $error("check command off rise");
   property p_clk_high;
      disable iff (sys_rst || !hdlc_enable) $rose(dclk) |=> dclk [*8];
   endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("demand clock high too short");
   property p_clk_low;
      disable iff (sys_rst || !hdlc_enable) $fell(dclk) |=> !dclk [*6];
   endproperty
   a_clk_low: assert property (p_clk_low)
      else $error("demand clock low too short");
   property p_check_len;
      $fell(fcs) && in_frame_reg |-> nfall_reg == (crc32_select ? 3'h4 : 3'h2);
   endproperty
   a_check_len: assert property (p_check_len)
      else $error("check command length wrong");
endmodule
`default_nettype wire

/* bench/hdlc_tx_byte_port_tb.sv */
// Bench joining terminal and framer, decoding and judging the line
`timescale 1ns/10ps
`default_nettype none
module hdlc_tx_byte_port_tb;
   logic sys_clk, sys_rst, hdlc_enable, crc32_select, line_bit;
   logic user_valid, user_last, user_abort, user_ready;
   logic line_bit_valid, pins_hdlc_mode;
   logic [7:0] user_data, sh;
   logic [7:0] rq[$];
   logic [7:0] fq[$];
   bit synced;
   int n_mismatch, n_checks, n_frame, n_abort, n_ready, ones, nb;
   htx_link_if link ();
   htx_framer u_htx_framer (.sys_clk, .sys_rst, .link, .hdlc_enable,
      .crc32_select, .line_bit, .line_bit_valid, .pins_hdlc_mode);
   htx_terminal u_htx_terminal (.sys_clk, .sys_rst, .link, .crc32_select,
      .user_data, .user_valid, .user_last, .user_abort, .user_ready);
   htx_link_monitor u_htx_link_monitor (.sys_clk, .sys_rst, .hdlc_enable,
      .crc32_select, .tx_byte_demand_clock(link.tx_byte_demand_clock),
      .tx_byte_input_bus(link.tx_byte_input_bus),
      .send_msg_cmd(link.send_msg_cmd),
      .append_check_cmd(link.append_check_cmd));
   initial
   begin
      sys_clk = 1'h0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Line decoder: drops stuffed zeros, finds flags and aborts
   always @(posedge sys_clk)
   begin
      if (user_ready === 1'h1)
         n_ready++;
      if (sys_rst || !hdlc_enable)
         synced = 1'h0;
      else if (line_bit_valid === 1'h1)
      begin
         ones = (line_bit === 1'h1) ? ones + 1 : ones;
         if (ones == 7)
         begin
            n_abort++;
            synced = 1'h0;
         end
         if (line_bit !== 1'h1 && ones == 6)
         begin
            if (synced && rq.size() > 0)
            begin
               fq = rq;
               n_frame++;
            end
            synced = 1'h1;
            rq = {};
            nb = 0;
         end
         else if (line_bit === 1'h1 || ones != 5)
         begin
            sh = {line_bit, sh[7:1]};
            nb++;
            if (nb == 8)
               rq.push_back(sh);
            nb = nb % 8;
         end
         ones = (line_bit === 1'h1) ? ones : 0;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Bounded wait for a counter to move; a stall ends the run
   task automatic wait_cnt(ref int cnt, input int n0, lim);
      int k;
      for (k = 0; k < lim && cnt == n0; k++)
         @(posedge sys_clk);
      if (cnt == n0)
      begin
         chk("wait", 1, 0);
         end_sim();
      end
   endtask
   // Reflected check value, preset ones, complemented
   function automatic logic [31:0] fcs(input logic [7:0] q[$], input bit w);
      logic [31:0] c;
      logic [31:0] pl;
      pl = w ? htx_pkg::HTX_CRC32_POLY : {16'h0000, htx_pkg::HTX_CRC16_POLY};
      c = w ? htx_pkg::HTX_CRC_PRESET : htx_pkg::HTX_CRC16_MASK;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? pl : 32'h00000000);
      return w ? ~c : ~c & htx_pkg::HTX_CRC16_MASK;
   endfunction
   // Feeds one frame through the terminal and checks the decoded frame
   task automatic send_frame(input logic [7:0] p[$], input bit w);
      logic [31:0] f;
      logic [7:0] e;
      int f0;
      f0 = n_frame;
      crc32_select <= w;
      foreach (p[i])
      begin
         user_data <= p[i];
         user_valid <= 1'h1;
         user_last <= (i == p.size() - 1);
         wait_cnt(n_ready, n_ready, 400);
      end
      user_valid <= 1'h0;
      user_last <= 1'h0;
      wait_cnt(n_frame, f0, 4000);
      f = fcs(p, w);
      chk("length", p.size() + (w ? 4 : 2), fq.size());
      foreach (fq[i])
      begin
         e = (i < p.size()) ? p[i] : 8'(f >> (8 * (i - p.size())));
         chk("byte", e, fq[i]);
      end
   endtask
   // Idle flags, then transmitter switched off and back on
   task automatic t_idle();
      int n;
      n = 0;
      user_data <= 8'hA5;
      repeat (600) @(posedge sys_clk);
      chk("synced", 1, synced);
      chk("frames", 0, n_frame + n_abort);
      chk("pins on", 1, pins_hdlc_mode);
      hdlc_enable <= 1'h0;
      repeat (3) @(posedge sys_clk);
      repeat (64)
      begin
         @(posedge sys_clk);
         n += (line_bit_valid !== 1'h0);
      end
      chk("bits off", 0, n);
      chk("pins off", 0, pins_hdlc_mode);
      hdlc_enable <= 1'h1;
      $display("test idle done");
   endtask
   // Both check widths, payload forcing stuffing and flag lookalikes
   task automatic t_frames();
      send_frame({8'hFF, 8'h7E, 8'h3E, 8'hF8}, 1'h0);
      $display("test crc16 done");
      send_frame({8'h7E, 8'hFF, 8'h01, 8'h80, 8'h1F}, 1'h1);
      $display("test crc32 done");
   endtask
   // Abort outside a frame: seven ones on the line and no frame
   task automatic t_abort();
      int f0;
      f0 = n_frame;
      user_abort <= 1'h1;
      wait_cnt(n_abort, n_abort, 600);
      user_abort <= 1'h0;
      repeat (300) @(posedge sys_clk);
      chk("frames", f0, n_frame);
      $display("test abort done");
   endtask
   initial
   begin
      sys_rst = 1'h1;
      hdlc_enable = 1'h0;
      crc32_select = 1'h0;
      user_data = 8'h00;
      user_valid = 1'h0;
      user_last = 1'h0;
      user_abort = 1'h0;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'h0;
      hdlc_enable <= 1'h1;
      t_idle();
      t_frames();
      t_abort();
      end_sim();
   end
endmodule
`default_nettype wire
